// [rtl/cidp_decode.sv]
// Instruction decoder with kernel and user privilege enforcement
//
// Functional notes
// RQ1 - Mixed compact and long instructions, no padding
// RQ2 - Source 62 takes next long immediate
// RQ3 - Source 63 gives word-aligned PC, read-only
// RQ4 - Compact 3-bit specifier maps r0-3, r12-15
// RQ5 - Long forms reach all 64 registers
// RQ6 - Branch offsets: 16 MB long, 512 B compact
// RQ7 - Compact branches: no delay slot, unconditional
// RQ8 - Compact flags only on test and compare
// RQ9 - Compact destination equals a source register; the stack, global and branch groups here do not (implied srcA or link dest)
// RQ10 - Some compact forms use implied registers
// RQ11 - Two source reads, one destination write
// RQ12 - Registers 0 to 28 unrestricted
// RQ13 - Auxiliary space only via dedicated instructions
// RQ14 - Two privilege levels, kernel at reset
// RQ15 - Kernel mode allows all privileged access
// RQ16 - User privileged access raises exception
// RQ17 - Current mode presented to memory management
// RQ18 - Five-bit group: 8 long, 24 compact
// RQ19 - Five-bit condition; low 16 internal flags
// RQ20 - Word after limm indicator is data
`include "cidp_defs.svh"
module cidp_decode
  import cidp_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic fetchValid,
  input wire logic [31:0] fetchWord,
  input wire logic [31:0] fetchPc,
  input wire logic userModeReq,
  input wire logic kernelModeReq,
  output logic fetchTake,
  output logic fetchIsCompact,
  output cidp_dec_s decOut,
  output logic kernelMode,
  output logic privException
);

  cidp_all_s st_reg;
  cidp_all_s st_next;

  // Map a compact 3-bit register field onto the full register number
  function automatic logic [5:0] mapCompact(input logic [2:0] r);
    mapCompact = r[2] ? {3'h1, r} : {3'h0, r}; // [RQ4]
  endfunction

  // Sign extend a field of given width to 32 bits
  function automatic logic [31:0] sext(input logic [31:0] v,
                                       input int w);
    logic [31:0] m;
    m = 32'hffffffff << w;
    sext = v[w-1] ? (v | m) : (v & ~m);
  endfunction

  // True when a source number selects the long immediate
  function automatic logic isLimm(input logic [5:0] r);
    isLimm = (r == `CIDP_LIMM_REG);
  endfunction

  logic [4:0] grp;
  logic compact;
  logic [5:0] subOp;
  logic [5:0] la;
  logic [5:0] lb;
  logic [5:0] lc;
  logic needLimm;
  logic privOp;
  logic [11:0] auxAddr;

  // Field extraction used by the instruction state branch and the assertions
  always_comb begin
    grp = fetchWord[31:27];
    compact = (grp >= `CIDP_NUM_LONG_GROUPS); // [RQ18] [RQ1]
    subOp = fetchWord[21:16];
    // Six-bit long-form register fields reach all 64 registers [RQ5]
    lb = {fetchWord[14:12], fetchWord[26:24]};
    lc = fetchWord[11:6];
    la = fetchWord[5:0];
    auxAddr = {6'h00, fetchWord[11:6]};
    needLimm = !compact && (isLimm(lb) || isLimm(lc)); // [RQ2]
    // Auxiliary access to low map or the privileged sub-op [RQ13]
    privOp = !compact && (grp == `CIDP_GRP_AUX_OPS) &&
             (subOp == `CIDP_SUBOP_PRIV ||
              ((subOp == `CIDP_SUBOP_AUXLD ||
                subOp == `CIDP_SUBOP_AUXST) &&
               auxAddr < `CIDP_PRIV_AUX_LIMIT));
  end

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.dec.valid = 1'b0;
    st_next.privExc = 1'b0;
    // Mode changes from the trap and return logic [RQ14]
    if (kernelModeReq) begin
      st_next.kernel = 1'b1;
    end else if (userModeReq) begin
      st_next.kernel = 1'b0;
    end
    if (fetchValid) begin
      unique case (st_reg.state)
        CIDP_ST_INSTR: begin
          st_next.dec = '0;
          st_next.dec.isCompact = compact;
          st_next.dec.group = grp;
          st_next.dec.pcAligned = {fetchPc[31:2], 2'b00}; // [RQ3]
          if (compact) begin
            // Destination is the first source [RQ9]
            st_next.dec.srcA = mapCompact(fetchWord[26:24]);
            st_next.dec.srcB = mapCompact(fetchWord[23:21]);
            st_next.dec.dest = st_next.dec.srcA; // [RQ9] [RQ11]
            st_next.dec.cond = 5'h00; // Always [RQ7]
            st_next.dec.condBase = 1'b1;
            // Only test and compare forms touch flags [RQ8]
            st_next.dec.setsFlags = (grp == `CIDP_COMPARE_GRP_S) ||
                                    (grp == `CIDP_BIT_TEST_GRP_S) ||
                                    (grp == `CIDP_TEST_GRP_S);
            if (grp == `CIDP_GRP_BRANCH_S) begin
              // Nine-bit halfword offset: +/-512 bytes [RQ6] [RQ7]
              st_next.dec.brOffset =
                sext({22'h0, fetchWord[24:16], 1'b0}, 10);
              st_next.dec.dest = `CIDP_BRANCH_LINK_REG; // [RQ10]
              st_next.dec.srcA = `CIDP_ALIGNED_PC_SOURCE_REG; // [RQ10]
            end else if (grp == `CIDP_STACK_GRP_S) begin
              // Stack pointer relative forms [RQ10]
              st_next.dec.srcA = `CIDP_STACK_POINTER_REG;
            end else if (grp == `CIDP_GLOBAL_GRP_S) begin
              // Global pointer relative forms [RQ10]
              st_next.dec.srcA = `CIDP_GLOBAL_POINTER_REG;
            end
          end else begin
            st_next.dec.srcA = lb; // [RQ11] [RQ12]
            st_next.dec.srcB = lc;
            st_next.dec.dest = la;
            st_next.dec.useLimmA = isLimm(lb); // [RQ2]
            st_next.dec.useLimmB = isLimm(lc); // [RQ2]
            st_next.dec.cond = fetchWord[4:0]; // [RQ19]
            st_next.dec.condBase =
              (fetchWord[4:0] <= `CIDP_CC_BASE_LAST); // [RQ19]
            st_next.dec.setsFlags = fetchWord[15];
            if (grp == `CIDP_GRP_BRANCH_L) begin
              // 24-bit halfword offset: +/-16 MB [RQ6]
              st_next.dec.brOffset = sext({7'h0, fetchWord[15:6],
                fetchWord[26:17], fetchWord[3:0], 1'b0}, 25);
            end
            st_next.dec.auxLoad = (grp == `CIDP_GRP_AUX_OPS) &&
                                  (subOp == `CIDP_SUBOP_AUXLD); // [RQ13]
            st_next.dec.auxStore = (grp == `CIDP_GRP_AUX_OPS) &&
                                   (subOp == `CIDP_SUBOP_AUXST);
          end
          if (privOp && !st_reg.kernel) begin
            // Kill the access and flag it [RQ16]
            st_next.privExc = 1'b1;
            st_next.dec.auxLoad = 1'b0;
            st_next.dec.auxStore = 1'b0;
            st_next.dec.valid = 1'b0;
          end else if (needLimm) begin
            st_next.state = CIDP_ST_LIMM; // [RQ20]
          end else begin
            st_next.dec.valid = 1'b1; // [RQ15]
          end
        end
        CIDP_ST_LIMM: begin
          // Word is data, never decoded [RQ20] [RQ2]
          st_next.dec.limm = fetchWord;
          st_next.dec.valid = 1'b1;
          st_next.state = CIDP_ST_INSTR;
        end
        // Illegal one-hot code: fall back to instruction decode
        default: begin
          st_next.state = CIDP_ST_INSTR;
        end
      endcase
    end
  end

  // State register with clock enable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.state <= CIDP_ST_INSTR;
      st_reg.kernel <= `CIDP_RESET_KERNEL; // [RQ14]
    end else if (clkEn) begin
      st_reg <= st_next;
    end
  end

  // Outputs other than fetchTake straight from flip-flops
  always_comb begin
    fetchTake = 1'b1;
    fetchIsCompact = st_reg.dec.isCompact;
    decOut = st_reg.dec;
    kernelMode = st_reg.kernel; // [RQ17]
    privException = st_reg.privExc;
  end

  // Reset leaves the core in kernel mode
  property p_reset_kernel;
    @(posedge core_clk) $rose(arst_n) |-> kernelMode;
  endproperty
  a_reset_kernel: assert property (p_reset_kernel) // [RQ14]
    else $error("not kernel after reset");

  // User privileged access raises exception next cycle
  property p_priv_exc;
    @(posedge core_clk) disable iff (!arst_n)
    (clkEn && fetchValid && st_reg.state == CIDP_ST_INSTR &&
     privOp && !kernelMode && !kernelModeReq)
      |=> privException && !decOut.valid;
  endproperty
  a_priv_exc: assert property (p_priv_exc) // [RQ16]
    else $error("privileged access not trapped");

  // Kernel never traps
  property p_kernel_ok;
    @(posedge core_clk) disable iff (!arst_n)
    (clkEn && kernelMode) |=> !privException;
  endproperty
  a_kernel_ok: assert property (p_kernel_ok) // [RQ15]
    else $error("kernel access trapped");

  // Limm word sequence: indicator then data word
  sequence s_limm_ind;
    clkEn && fetchValid && st_reg.state == CIDP_ST_INSTR &&
    needLimm && (kernelMode || !privOp);
  endsequence
  property p_limm;
    @(posedge core_clk) disable iff (!arst_n)
    s_limm_ind ##1 (clkEn && fetchValid)
      |=> decOut.valid && decOut.limm == $past(fetchWord);
  endproperty
  a_limm: assert property (p_limm) // [RQ2]
    else $error("long immediate not captured");

  // Limm indicator is not issued before its data word arrives
  property p_limm_nodec;
    @(posedge core_clk) disable iff (!arst_n)
    s_limm_ind |=> !decOut.valid;
  endproperty
  a_limm_nodec: assert property (p_limm_nodec) // [RQ20]
    else $error("limm indicator decoded early");

  // Aligned PC has low bits zero
  property p_aligned_pc;
    @(posedge core_clk) disable iff (!arst_n)
    decOut.valid |-> decOut.pcAligned[1:0] == 2'b00;
  endproperty
  a_aligned_pc: assert property (p_aligned_pc) // [RQ3]
    else $error("aligned PC low bits set");

  // Compact srcB within the reduced set for groups above the global group
  property p_compact_regs;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact && decOut.group > `CIDP_GLOBAL_GRP_S)
      |-> decOut.srcB < 6'h04 ||
          (decOut.srcB >= 6'h0c && decOut.srcB <= 6'h0f);
  endproperty
  a_compact_regs: assert property (p_compact_regs) // [RQ4]
    else $error("compact register out of reduced set");

  // Compact forms are unconditional
  property p_compact_cond;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact) |-> decOut.cond == 5'h00;
  endproperty
  a_compact_cond: assert property (p_compact_cond) // [RQ7]
    else $error("compact instruction conditional");

  // Group classification matches length flag
  property p_group;
    @(posedge core_clk) disable iff (!arst_n)
    decOut.valid |->
      decOut.isCompact == (decOut.group >= `CIDP_NUM_LONG_GROUPS);
  endproperty
  a_group: assert property (p_group) // [RQ18]
    else $error("group length mismatch");

  // User request drops privilege when kernel is not asked for
  property p_mode_user;
    @(posedge core_clk) disable iff (!arst_n)
    (clkEn && userModeReq && !kernelModeReq) |=> !kernelMode;
  endproperty
  a_mode_user: assert property (p_mode_user) // [RQ14]
    else $error("user mode request ignored");

  // Kernel request always wins
  property p_mode_kernel;
    @(posedge core_clk) disable iff (!arst_n)
    (clkEn && kernelModeReq) |=> kernelMode;
  endproperty
  a_mode_kernel: assert property (p_mode_kernel) // [RQ14]
    else $error("kernel mode request ignored");

  // Compact destination doubles as first source below the stack group
  property p_compact_dest;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact &&
     decOut.group < `CIDP_STACK_GRP_S) |-> decOut.dest == decOut.srcA;
  endproperty
  a_compact_dest: assert property (p_compact_dest) // [RQ9]
    else $error("compact destination differs from source");

  // Compact branch links and reads the aligned pc implicitly
  property p_compact_link;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact &&
     decOut.group == `CIDP_GRP_BRANCH_S)
      |-> decOut.dest == `CIDP_BRANCH_LINK_REG &&
          decOut.srcA == `CIDP_ALIGNED_PC_SOURCE_REG;
  endproperty
  a_compact_link: assert property (p_compact_link) // [RQ10]
    else $error("compact branch implied registers wrong");

  // Compact branch offset stays within 512 bytes, halfword aligned
  property p_short_range;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact &&
     decOut.group == `CIDP_GRP_BRANCH_S)
      |-> $signed(decOut.brOffset) >= -512 &&
          $signed(decOut.brOffset) <= 510 && !decOut.brOffset[0];
  endproperty
  a_short_range: assert property (p_short_range) // [RQ6]
    else $error("compact branch offset out of range");

  // Long branch offset stays within 16 megabytes, halfword aligned
  property p_long_range;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && !decOut.isCompact &&
     decOut.group == `CIDP_GRP_BRANCH_L)
      |-> $signed(decOut.brOffset) >= -16777216 &&
          $signed(decOut.brOffset) <= 16777214 && !decOut.brOffset[0];
  endproperty
  a_long_range: assert property (p_long_range) // [RQ6]
    else $error("long branch offset out of range");

  // Compact forms never carry a long immediate
  property p_compact_nolimm;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && decOut.isCompact)
      |-> !decOut.useLimmA && !decOut.useLimmB;
  endproperty
  a_compact_nolimm: assert property (p_compact_nolimm) // [RQ5]
    else $error("compact form uses long immediate");

  // A trapped access reaches execute as nothing at all
  property p_trap_kills;
    @(posedge core_clk) disable iff (!arst_n)
    privException |-> !decOut.valid && !decOut.auxLoad &&
                      !decOut.auxStore;
  endproperty
  a_trap_kills: assert property (p_trap_kills) // [RQ16]
    else $error("trapped access still issued");

  // Long forms flag the base condition range
  property p_cond_base;
    @(posedge core_clk) disable iff (!arst_n)
    (decOut.valid && !decOut.isCompact)
      |-> decOut.condBase == (decOut.cond <= `CIDP_CC_BASE_LAST);
  endproperty
  a_cond_base: assert property (p_cond_base) // [RQ19]
    else $error("base condition flag wrong");

endmodule

// [rtl/cidp_defs.svh]
// Constant macros for the compact instruction decode and privilege block
`ifndef CIDP_DEFS_SVH
`define CIDP_DEFS_SVH
`define CIDP_LIMM_REG 6'h3e
`define CIDP_ALIGNED_PC_SOURCE_REG 6'h3f
`define CIDP_GENERAL_LAST 6'h1c
`define CIDP_GLOBAL_POINTER_REG 6'h1a
`define CIDP_FRAME_POINTER_REG 6'h1b
`define CIDP_STACK_POINTER_REG 6'h1c
`define CIDP_BRANCH_LINK_REG 6'h1f
`define CIDP_NUM_LONG_GROUPS 5'h08
`define CIDP_CC_BASE_LAST 5'h0f
`define CIDP_RESET_KERNEL 1'b1
`define CIDP_GRP_BRANCH_L 5'h00
`define CIDP_GRP_AUX_OPS 5'h04
`define CIDP_GRP_BRANCH_S 5'h1f
`define CIDP_SUBOP_AUXLD 6'h2a
`define CIDP_SUBOP_AUXST 6'h2b
`define CIDP_SUBOP_PRIV 6'h2f
`define CIDP_COMPARE_GRP_S 5'h1c
`define CIDP_BIT_TEST_GRP_S 5'h17
`define CIDP_TEST_GRP_S 5'h0f
`define CIDP_STACK_GRP_S 5'h18
`define CIDP_GLOBAL_GRP_S 5'h19
`define CIDP_PRIV_AUX_LIMIT 12'h400
`endif

// [rtl/cidp_pkg.sv]
// Types shared by the compact instruction decode and privilege block
package cidp_pkg;
  // Decoder sequencing state
  typedef enum logic [1:0] {
    CIDP_ST_INSTR = 2'b01,
    CIDP_ST_LIMM = 2'b10
  } cidp_state_e;
  // Decoded instruction handed to execute
  typedef struct packed {
    logic valid;
    logic isCompact;
    logic [4:0] group;
    logic [5:0] srcA;
    logic [5:0] srcB;
    logic [5:0] dest;
    logic useLimmA;
    logic useLimmB;
    logic [31:0] limm;
    logic [31:0] pcAligned;
    logic [4:0] cond;
    logic condBase;
    logic setsFlags;
    logic [31:0] brOffset;
    logic auxLoad;
    logic auxStore;
  } cidp_dec_s;
  // Whole module state
  typedef struct packed {
    cidp_state_e state;
    cidp_dec_s dec;
    logic kernel;
    logic privExc;
  } cidp_all_s;
endpackage

// [testbench/cidp_fetch_model.sv]
// Fetch stage model that feeds words to the decoder
module cidp_fetch_model (
  input wire logic core_clk,
  output logic fetchValid,
  output logic [31:0] fetchWord,
  output logic [31:0] fetchPc
);
  timeunit 1ns;
  timeprecision 100ps;
  // Nothing offered at time zero
  initial begin
    fetchValid = 1'b0;
    fetchWord = 32'h0000_0000;
    fetchPc = 32'h0000_0000;
  end
  // Offer one word from a rising edge until the edge that takes it
  task automatic issue(input logic [31:0] w, input logic [31:0] pc);
    fetchValid <= 1'b1;
    fetchWord <= w;
    fetchPc <= pc;
    @(posedge core_clk);
  endtask
  // Released bus shows the inverse so stale data is never mistaken
  task automatic idle();
    fetchValid <= 1'b0;
    fetchWord <= ~fetchWord;
    fetchPc <= ~fetchPc;
  endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the decode and privilege block
module tb
  import cidp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk;
  logic arst_n;
  logic clkEn;
  logic userModeReq;
  logic kernelModeReq;
  logic fetchValid;
  logic [31:0] fetchWord;
  logic [31:0] fetchPc;
  logic fetchTake;
  logic fetchIsCompact;
  cidp_dec_s decOut;
  logic kernelMode;
  logic privException;
  int num_errors;
  int cmp_count;
  cidp_decode i_cidp_decode (.core_clk(core_clk), .arst_n(arst_n),
    .clkEn(clkEn), .fetchValid(fetchValid), .fetchWord(fetchWord),
    .fetchPc(fetchPc), .userModeReq(userModeReq),
    .kernelModeReq(kernelModeReq), .fetchTake(fetchTake),
    .fetchIsCompact(fetchIsCompact), .decOut(decOut),
    .kernelMode(kernelMode), .privException(privException));
  cidp_fetch_model i_cidp_fetch_model (.core_clk(core_clk),
    .fetchValid(fetchValid), .fetchWord(fetchWord), .fetchPc(fetchPc));
  // 100 ns clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Compare one value and count it
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Single word, then sample mid-cycle after the answer lands
  task automatic run1(input logic [31:0] w, input logic [31:0] pc);
    @(posedge core_clk);
    i_cidp_fetch_model.issue(w, pc);
    i_cidp_fetch_model.idle();
    @(negedge core_clk);
  endtask
  // Pulse one mode request line pair for one cycle
  task automatic mode_req(input logic u, input logic k);
    @(posedge core_clk);
    userModeReq <= u;
    kernelModeReq <= k;
    @(posedge core_clk);
    userModeReq <= 1'b0;
    kernelModeReq <= 1'b0;
    @(negedge core_clk);
  endtask
  // Every group code: length class, aligned pc; compact codes also flags, condition
  task automatic t_groups();
    logic [31:0] pc;
    for (int g = 0; g < 32; g++) begin
      pc = 32'h0000_1003 + 32'(g << 4);
      run1({5'(g), 27'h0}, pc);
      chk("valid", 32'h1, 32'(decOut.valid));
      chk("compact", 32'(g >= 8), 32'(decOut.isCompact));
      chk("fetchIsCompact", 32'(g >= 8), 32'(fetchIsCompact));
      chk("pcAligned", pc & 32'hffff_fffc, decOut.pcAligned);
      if (g >= 8) begin
        chk("setsFlags", 32'(g == 28 || g == 23 || g == 15),
            32'(decOut.setsFlags));
        chk("cond", 32'h0, 32'(decOut.cond));
      end
    end
  endtask
  // Long word with immediate operand, then a compact word at once
  task automatic t_limm();
    @(posedge core_clk);
    i_cidp_fetch_model.issue(32'h2000_0f80, 32'h0000_2000);
    i_cidp_fetch_model.issue(32'hdead_beef, 32'h0000_2004);
    // Next word goes out at once while the answer is looked at mid-cycle
    fork
      i_cidp_fetch_model.issue(32'h6800_0000, 32'h0000_2008);
      begin
        @(negedge core_clk);
        chk("valid", 32'h1, 32'(decOut.valid));
        chk("limm", 32'hdead_beef, decOut.limm);
        chk("useLimm", 32'h1, 32'(decOut.useLimmB));
        chk("limm group", 32'h4, 32'(decOut.group));
      end
    join
    i_cidp_fetch_model.idle();
    @(negedge core_clk);
    chk("compact", 32'h1, 32'(decOut.isCompact));
    chk("compact valid", 32'h1, 32'(decOut.valid));
  endtask
  // Compact 3-bit specifier to the reduced register set
  task automatic t_regmap();
    int ea;
    int eb;
    for (int v = 0; v < 8; v++) begin
      ea = (v < 4) ? v : v + 8;
      eb = (v > 3) ? 7 - v : 15 - v;
      run1({5'h1c, 3'(v), 3'(7 - v), 21'h0}, 32'h0000_3000);
      chk("srcA", 32'(ea), 32'(decOut.srcA));
      chk("srcB", 32'(eb), 32'(decOut.srcB));
      chk("dest", 32'(ea), 32'(decOut.dest));
      chk("setsFlags", 32'h1, 32'(decOut.setsFlags));
    end
  endtask
  // Kernel, user and back, with privileged operations
  task automatic t_priv();
    run1(32'h202f_0000, 32'h0000_4000);
    chk("kernel priv valid", 32'h1, 32'(decOut.valid));
    chk("kernel priv exc", 32'h0, 32'(privException));
    run1(32'h202a_0140, 32'h0000_3ffc);
    chk("kernel aux load", 32'h1, 32'(decOut.auxLoad));
    mode_req(1'b1, 1'b0);
    chk("kernelMode", 32'h0, 32'(kernelMode));
    run1(32'h202f_0000, 32'h0000_4004);
    chk("user priv exc", 32'h1, 32'(privException));
    chk("user priv valid", 32'h0, 32'(decOut.valid));
    run1(32'h202a_0140, 32'h0000_4008);
    chk("user aux exc", 32'h1, 32'(privException));
    chk("user aux load", 32'h0, 32'(decOut.auxLoad));
    mode_req(1'b1, 1'b1);
    chk("kernelMode", 32'h1, 32'(kernelMode));
  endtask
  // Clock enable low freezes decoding
  task automatic t_clken();
    @(posedge core_clk);
    clkEn <= 1'b0;
    run1(32'h6800_0000, 32'h0000_5000);
    chk("frozen valid", 32'h0, 32'(decOut.valid));
    @(posedge core_clk);
    clkEn <= 1'b1;
  endtask
  // Compact branch at its negative limit, long branch two bytes above its own
  task automatic t_branch();
    run1(32'hf900_0000, 32'h0000_7000);
    chk("short offset", 32'hffff_fe00, decOut.brOffset);
    chk("short link", 32'h1f, 32'(decOut.dest));
    chk("short pc src", 32'h3f, 32'(decOut.srcA));
    chk("short cond", 32'h0, 32'(decOut.cond));
    run1(32'h0000_8011, 32'h0000_7004);
    chk("long offset", 32'hff00_0002, decOut.brOffset);
    chk("long cond", 32'h11, 32'(decOut.cond));
    chk("long cond base", 32'h0, 32'(decOut.condBase));
  endtask
  // Reset in mid-run from user mode returns to kernel
  task automatic t_reset();
    mode_req(1'b1, 1'b0);
    chk("user before reset", 32'h0, 32'(kernelMode));
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(negedge core_clk);
    chk("mid reset kernel", 32'h1, 32'(kernelMode));
    chk("mid reset valid", 32'h0, 32'(decOut.valid));
    @(posedge core_clk);
    arst_n <= 1'b1;
    run1(32'h202f_0000, 32'h0000_6000);
    chk("post reset priv", 32'h1, 32'(decOut.valid));
    chk("post reset exc", 32'h0, 32'(privException));
  endtask
  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    num_errors = 0;
    cmp_count = 0;
    arst_n = 1'b0;
    clkEn = 1'b1;
    userModeReq = 1'b0;
    kernelModeReq = 1'b0;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset kernelMode", 32'h1, 32'(kernelMode));
    chk("reset exc", 32'h0, 32'(privException));
    chk("fetchTake", 32'h1, 32'(fetchTake));
    @(posedge core_clk);
    arst_n <= 1'b1;
    t_groups();
    t_limm();
    t_regmap();
    t_priv();
    t_clken();
    t_branch();
    t_reset();
    tally_and_finish();
  end
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge core_clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
